// [inc/ump_pkg.sv]
// Package with register map, field layout, selections and poll timing for the port map
package ump_pkg;

  // Register indices; byte address on APB is four times the index
  localparam logic [9:0]  IDX_CTRL    = 10'h100;
  localparam logic [9:0]  IDX_STAT    = 10'h101;
  localparam logic [9:0]  IDX_AVAIL_L = 10'h102;
  localparam logic [9:0]  IDX_AVAIL_H = 10'h103;
  localparam logic [9:0]  IDX_PMAP    = 10'h112;
  localparam logic [9:0]  IDX_QCFG    = 10'h170;

  // Control register fields
  localparam int unsigned CTRL_EN     = 0;
  localparam int unsigned CTRL_BUS8   = 1;
  localparam int unsigned CTRL_QNORM  = 2;
  localparam logic [2:0]  CTRL_RST    = 3'h4;

  // Status register fields
  localparam int unsigned STAT_BAD    = 0;
  localparam int unsigned STAT_BUSY   = 1;
  localparam int unsigned STAT_QLO    = 4;

  localparam logic [15:0] PMAP_RST    = 16'h0000;
  localparam logic [2:0]  QCFG_RST    = 3'h2;
  localparam logic [2:0]  QNUM_FOUR   = 3'h4;
  localparam logic [2:0]  QNUM_TWO    = 3'h2;
  localparam logic [2:0]  QNUM_NONE   = 3'h0;
  localparam logic [5:0]  PORT_LAST   = 6'h3F;
  localparam logic [5:0]  PORTS16_MAX = 6'h20;

  // Link cycles between address drive and clav sample: the two synchroniser stages only, PHY answers in the same cycle
  localparam logic [1:0]  POLL_WAIT   = 2'h2;

  typedef enum logic [3:0] {
    SEL_A0C4 = 4'h0,
    SEL_A1C4 = 4'h2,
    SEL_A2C4 = 4'h5,
    SEL_A3C4 = 4'h9,
    SEL_A4C4 = 4'hE
  } ump_sel_t;

  typedef enum logic [1:0] {
    P_IDLE   = 2'b00,
    P_DRIVE  = 2'b01,
    P_WAIT   = 2'b10,
    P_SAMPLE = 2'b11
  } ump_poll_t;

  // Returns {valid, clav line, address} for one port number
  function automatic logic [6:0] ump_map(input logic [3:0] sel, input logic bus8,
                                         input logic [5:0] port);
    logic       ok;
    logic [1:0] line;
    logic [3:0] addr;
    ok   = 1'b0;
    line = 2'b00;
    addr = 4'h0;
    case (sel)
      SEL_A0C4: begin
        ok   = !bus8 && (port[5:3] == 3'h0) && !port[0];
        line = port[2:1];
      end
      SEL_A1C4: begin
        ok   = !bus8 && (port[5:4] == 2'h0) && !port[0];
        line = port[3:2];
        addr = {2'b00, port[1], 1'b0};
      end
      SEL_A2C4: begin
        ok   = !bus8 && !port[5] && !port[0];
        line = port[4:3];
        addr = {1'b0, port[2:1], 1'b0};
      end
      SEL_A3C4: begin
        ok   = !bus8 && !port[5];
        line = port[4:3];
        addr = {1'b0, port[2:0]};
      end
      SEL_A4C4: begin
        ok   = bus8;
        line = port[5:4];
        addr = port[3:0];
      end
      default: ok = 1'b0;
    endcase
    return {ok, line, addr};
  endfunction : ump_map

endpackage : ump_pkg

// [logic/ump_port_map.sv]
// Port map selector: APB registers, UTOPIA poller on the link clock, clav map return

module ump_port_map (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        link_clk,
  input  wire logic [3:0]  u_clav,
  output logic      [3:0]  u_addr,
  output logic      [63:0] cell_avail,
  output logic      [2:0]  queues_per_phy,
  output logic             sel_unsupported
);

  // Register domain
  logic [2:0]  ctrl_q, ctrl_d;
  logic [15:0] pmap_q, pmap_d;
  logic [2:0]  qcfg_q, qcfg_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic [2:0]  qnum_q, qnum_d;
  logic        bad_q, bad_d;
  logic [63:0] avail_q, avail_d;
  logic        ack_q, ack_d;
  logic        req_s1_q, req_s2_q;
  logic        busy_s1_q, busy_s2_q;
  logic [9:0]  idx;
  logic [6:0]  sel_map;
  logic        sel_ok;
  logic        wr_en;

  // Link domain state, declared here so the return path can name it
  logic        req_q;
  logic [63:0] snap_q;
  logic        busy_q;

  assign idx    = paddr[11:2];
  assign sel_map = ump_pkg::ump_map(pmap_q[3:0], ctrl_q[ump_pkg::CTRL_BUS8], 6'h00);
  assign sel_ok  = sel_map[6];
  assign wr_en  = psel && penable && pready_q && pwrite;

  always_comb begin
    ctrl_d    = ctrl_q;
    pmap_d    = pmap_q;
    qcfg_d    = qcfg_q;
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    pready_d  = 1'b0;
    ack_d     = ack_q;
    avail_d   = avail_q;
    // One wait state so read data leaves straight from a flop
    if (psel && penable && !pready_q) begin
      pready_d  = 1'b1;
      pslverr_d = 1'b0;
      prdata_d  = 32'h0000_0000;
      case (idx)
        ump_pkg::IDX_CTRL:    prdata_d[2:0]  = ctrl_q;
        ump_pkg::IDX_STAT:    prdata_d[6:0]  = {qnum_q, 2'b00, busy_s2_q, bad_q};
        ump_pkg::IDX_AVAIL_L: prdata_d       = avail_q[31:0];
        ump_pkg::IDX_AVAIL_H: prdata_d       = avail_q[63:32];
        ump_pkg::IDX_PMAP:    prdata_d[15:0] = pmap_q;
        ump_pkg::IDX_QCFG:    prdata_d[2:0]  = qcfg_q;
        default:              pslverr_d      = 1'b1;
      endcase
    end
    if (wr_en) begin
      case (idx)
        ump_pkg::IDX_CTRL: ctrl_d = pwdata[2:0];
        ump_pkg::IDX_PMAP: pmap_d = pwdata[15:0];
        ump_pkg::IDX_QCFG: qcfg_d = pwdata[2:0];
        default:           ctrl_d = ctrl_q;
      endcase
    end
    // A new poll snapshot is taken once per handshake
    if (req_s2_q != ack_q) begin
      avail_d = snap_q;
      ack_d   = req_s2_q;
    end
  end

  // Queue share per PHY and the unsupported flag follow the live selection
  always_comb begin
    bad_d  = !sel_ok;
    qnum_d = ump_pkg::QNUM_NONE;
    if (sel_ok) begin
      case (pmap_q[3:0])
        ump_pkg::SEL_A0C4,
        ump_pkg::SEL_A1C4,
        ump_pkg::SEL_A2C4: qnum_d = ump_pkg::QNUM_FOUR;
        ump_pkg::SEL_A3C4: qnum_d = ctrl_q[ump_pkg::CTRL_QNORM] ? ump_pkg::QNUM_TWO
                                                                 : qcfg_q;
        ump_pkg::SEL_A4C4: qnum_d = ump_pkg::QNUM_TWO;
        default:           qnum_d = ump_pkg::QNUM_NONE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q    <= ump_pkg::CTRL_RST;
      pmap_q    <= ump_pkg::PMAP_RST;
      qcfg_q    <= ump_pkg::QCFG_RST;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      qnum_q    <= ump_pkg::QNUM_NONE;
      bad_q     <= 1'b0;
      avail_q   <= 64'h0000_0000_0000_0000;
      ack_q     <= 1'b0;
      req_s1_q  <= 1'b0;
      req_s2_q  <= 1'b0;
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      pmap_q    <= pmap_d;
      qcfg_q    <= qcfg_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      qnum_q    <= qnum_d;
      bad_q     <= bad_d;
      avail_q   <= avail_d;
      ack_q     <= ack_d;
      req_s1_q  <= req_q;
      req_s2_q  <= req_s1_q;
      busy_s1_q <= busy_q;
      busy_s2_q <= busy_s1_q;
    end
  end

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign cell_avail      = avail_q;
  assign queues_per_phy  = qnum_q;
  assign sel_unsupported = bad_q;

  // Link domain; selection and width are quasi-static, qualified by the synced enable
  logic [1:0]           lrst_q;
  logic                 lrst_n;
  logic                 en_s1_q, en_s2_q;
  logic                 ack_s1_q, ack_s2_q;
  logic [3:0]           clav_s1_q, clav_s2_q;
  ump_pkg::ump_poll_t   st_q, st_d;
  logic [5:0]           port_q, port_d;
  logic [3:0]           addr_q, addr_d;
  logic [1:0]           line_q, line_d;
  logic [1:0]           wcnt_q, wcnt_d;
  logic [3:0]           sel_l_q, sel_l_d;
  logic                 bus8_l_q, bus8_l_d;
  logic [63:0]          acc_q, acc_d;
  logic [63:0]          snap_d;
  logic                 req_d;
  logic [6:0]           map;

  // Link reset: asserted at once, released on link clock edges
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      lrst_q <= 2'b00;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end
  assign lrst_n = lrst_q[1];

  assign map = ump_pkg::ump_map(sel_l_q, bus8_l_q, port_q);

  always_comb begin
    st_d     = st_q;
    port_d   = port_q;
    addr_d   = addr_q;
    line_d   = line_q;
    wcnt_d   = wcnt_q;
    sel_l_d  = sel_l_q;
    bus8_l_d = bus8_l_q;
    acc_d    = acc_q;
    snap_d   = snap_q;
    req_d    = req_q;
    case (st_q)
      // Selection is quasi-static while enabled, so it is captured once at the start
      ump_pkg::P_IDLE: begin
        if (en_s2_q && sel_ok) begin
          sel_l_d  = pmap_q[3:0];
          bus8_l_d = ctrl_q[ump_pkg::CTRL_BUS8];
          port_d   = 6'h00;
          st_d     = ump_pkg::P_DRIVE;
        end
      end
      ump_pkg::P_DRIVE: begin
        if (!en_s2_q) begin
          st_d = ump_pkg::P_IDLE;
        end else if (map[6]) begin
          addr_d = map[3:0];
          line_d = map[5:4];
          wcnt_d = 2'h0;
          st_d   = ump_pkg::P_WAIT;
        end else begin
          acc_d[port_q] = 1'b0;
          port_d        = port_q + 6'h01;
        end
      end
      ump_pkg::P_WAIT: begin
        wcnt_d = wcnt_q + 2'h1;
        if (wcnt_q == ump_pkg::POLL_WAIT - 2'h1) begin
          st_d = ump_pkg::P_SAMPLE;
        end
      end
      ump_pkg::P_SAMPLE: begin
        acc_d[port_q] = clav_s2_q[line_q];
        port_d        = port_q + 6'h01;
        st_d          = ump_pkg::P_DRIVE;
      end
      default: st_d = ump_pkg::P_IDLE;
    endcase
    // Round end; a snapshot still unacknowledged is not overwritten
    if (port_q == ump_pkg::PORT_LAST && (st_q == ump_pkg::P_SAMPLE ||
        (st_q == ump_pkg::P_DRIVE && en_s2_q && !map[6]))) begin
      if (ack_s2_q == req_q) begin
        snap_d = acc_d;
        req_d  = !req_q;
      end
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      en_s1_q   <= 1'b0;
      en_s2_q   <= 1'b0;
      ack_s1_q  <= 1'b0;
      ack_s2_q  <= 1'b0;
      clav_s1_q <= 4'h0;
      clav_s2_q <= 4'h0;
      st_q      <= ump_pkg::P_IDLE;
      port_q    <= 6'h00;
      addr_q    <= 4'h0;
      line_q    <= 2'h0;
      wcnt_q    <= 2'h0;
      sel_l_q   <= 4'h0;
      bus8_l_q  <= 1'b0;
      acc_q     <= 64'h0000_0000_0000_0000;
      snap_q    <= 64'h0000_0000_0000_0000;
      req_q     <= 1'b0;
      busy_q    <= 1'b0;
    end else begin
      en_s1_q   <= ctrl_q[ump_pkg::CTRL_EN];
      en_s2_q   <= en_s1_q;
      ack_s1_q  <= ack_q;
      ack_s2_q  <= ack_s1_q;
      clav_s1_q <= u_clav;
      clav_s2_q <= clav_s1_q;
      st_q      <= st_d;
      port_q    <= port_d;
      addr_q    <= addr_d;
      line_q    <= line_d;
      wcnt_q    <= wcnt_d;
      sel_l_q   <= sel_l_d;
      bus8_l_q  <= bus8_l_d;
      acc_q     <= acc_d;
      snap_q    <= snap_d;
      req_q     <= req_d;
      busy_q    <= (st_d != ump_pkg::P_IDLE);
    end
  end

  assign u_addr = addr_q;
  // Checks
  a_port_limit16: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (st_q == ump_pkg::P_SAMPLE && !bus8_l_q) |-> (port_q < ump_pkg::PORTS16_MAX))
    else $error("port beyond 32 polled in 16-bit mode");
  a_line_addr_pair: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (st_q == ump_pkg::P_DRIVE && map[6] && en_s2_q) |=> ##2
      (st_q == ump_pkg::P_SAMPLE && {line_q, addr_q} == $past(map[5:0], 3)))
    else $error("line and address do not match port");
  a_sel_decode: assert property (@(posedge clk) disable iff (!arst_n)
    (ctrl_q[ump_pkg::CTRL_BUS8] ? (pmap_q[3:0] == 4'hE)
                                : (pmap_q[3:0] inside {4'h0, 4'h2, 4'h5, 4'h9})) |=> !bad_q)
    else $error("documented selection flagged unsupported");
  a_sel_reject: assert property (@(posedge clk) disable iff (!arst_n)
    !(ctrl_q[ump_pkg::CTRL_BUS8] ? (pmap_q[3:0] == 4'hE)
                                 : (pmap_q[3:0] inside {4'h0, 4'h2, 4'h5, 4'h9})) |=> bad_q)
    else $error("undocumented selection not flagged");
  a_queues_four: assert property (@(posedge clk) disable iff (!arst_n)
    (!ctrl_q[ump_pkg::CTRL_BUS8] && pmap_q[3:0] inside {4'h0, 4'h2, 4'h5})
      |=> (qnum_q == 3'h4))
    else $error("selection should give four queues");
  a_a1_addr: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (st_q == ump_pkg::P_SAMPLE && sel_l_q == 4'h2)
      |-> (addr_q[3:2] == 2'b00 && !addr_q[0] && port_q < 6'h10))
    else $error("one-address selection out of range");
  a_a2_addr: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (st_q == ump_pkg::P_SAMPLE && sel_l_q == 4'h5)
      |-> (!addr_q[3] && !addr_q[0] && addr_q[2:1] == port_q[2:1]))
    else $error("two-address selection wrong");
  a_a3_addr: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (st_q == ump_pkg::P_SAMPLE && sel_l_q == 4'h9)
      |-> (addr_q == {1'b0, port_q[2:0]} && line_q == port_q[4:3]))
    else $error("three-address selection wrong");
  a_a3_queues: assert property (@(posedge clk) disable iff (!arst_n)
    (!ctrl_q[ump_pkg::CTRL_BUS8] && pmap_q[3:0] == 4'h9)
      |=> (qnum_q == ($past(ctrl_q[ump_pkg::CTRL_QNORM]) ? 3'h2 : $past(qcfg_q))))
    else $error("queue count wrong under 1001");
  a_hi_ports8: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (st_q == ump_pkg::P_SAMPLE && bus8_l_q && sel_l_q == 4'hE && port_q[5:4] == 2'b11)
      |-> (line_q == 2'd3 && addr_q == port_q[3:0]))
    else $error("upper ports not on line 3");
  a_a0_even: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (st_q == ump_pkg::P_SAMPLE && sel_l_q == 4'h0)
      |-> (addr_q == 4'h0 && !port_q[0] && line_q == port_q[2:1]))
    else $error("level-one port mapping wrong");
  a_no_poll_bad: assert property (@(posedge link_clk) disable iff (!lrst_n)
    $rose(st_q != ump_pkg::P_IDLE) |-> (bus8_l_q ? (sel_l_q == 4'hE)
                                                 : (sel_l_q inside {4'h0, 4'h2, 4'h5, 4'h9})))
    else $error("polling under unsupported selection");
  a_apb_wait: assert property (@(posedge clk) disable iff (!arst_n)
    (psel && penable && !pready_q) |=> (pready_q ##1 !pready_q))
    else $error("APB answer not one wait state");
endmodule : ump_port_map

// [test/ump_phy_model.sv]
// Behavioural UTOPIA PHY group: one clav line per group, one device per address
module ump_phy_model (
  input  wire logic        link_clk,
  input  wire logic [3:0]  u_addr,
  input  wire logic [63:0] tab,
  output logic      [3:0]  u_clav
);
  timeunit 1ns;
  timeprecision 1ps;

  // Clav follows the address within the same link cycle; the poller allows no extra cycle
  always_comb begin
    for (int l = 0; l < 4; l++) begin
      u_clav[l] = tab[l*16+u_addr];
    end
  end
endmodule : ump_phy_model

// [test/ump_port_map_tb.sv]
// Self-checking bench for the port map selector
module ump_port_map_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        arst_n;
  logic        link_clk;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  u_clav;
  logic [3:0]  u_addr;
  logic [63:0] cell_avail;
  logic [2:0]  queues_per_phy;
  logic        sel_unsupported;
  logic [63:0] tab;
  int          error_cnt;
  int          checks_done;

  // Entries are {selection, 8-bit mode, normal queuing}
  localparam logic [5:0] CASES [9] = '{6'h01, 6'h09, 6'h15, 6'h25, 6'h24,
                                       6'h3B, 6'h39, 6'h27, 6'h0D};

  ump_port_map u_ump_port_map (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_clk(link_clk), .u_clav(u_clav), .u_addr(u_addr),
    .cell_avail(cell_avail), .queues_per_phy(queues_per_phy),
    .sel_unsupported(sel_unsupported)
  );

  ump_phy_model u_ump_phy_model (
    .link_clk(link_clk), .u_addr(u_addr), .tab(tab), .u_clav(u_clav)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end

  // Returns {valid, line, address} for a port, worked out per selection
  function automatic logic [6:0] exp_pos(input logic [3:0] sel, input logic b8, input int p);
    int ok;
    int ln;
    int ad;
    ok = 0;
    ln = 0;
    ad = 0;
    case (sel)
      4'h0: begin ok = !b8 && p < 8 && p % 2 == 0; ln = p / 2; end
      4'h2: begin ok = !b8 && p < 16 && p % 2 == 0; ln = p / 4; ad = p % 4; end
      4'h5: begin ok = !b8 && p < 32 && p % 2 == 0; ln = p / 8; ad = p % 8; end
      4'h9: begin ok = !b8 && p < 32; ln = p / 8; ad = p % 8; end
      4'hE: begin ok = b8; ln = p / 16; ad = p % 16; end
      default: ok = 0;
    endcase
    return {ok[0], ln[1:0], ad[3:0]};
  endfunction : exp_pos

  function automatic logic [2:0] exp_q(input logic [3:0] sel, input logic b8,
                                       input logic qn, input logic [2:0] qv);
    logic [6:0] m0;
    m0 = exp_pos(sel, b8, 0);
    if (!m0[6]) return 3'h0;
    if (b8) return 3'h2;
    if (sel == 4'h9) return qn ? 3'h2 : qv;
    return 3'h4;
  endfunction : exp_q

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Request stands until pready is seen high at a rising edge; the answer is taken there
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      wrap_up();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic run_case(input logic [3:0] sel, input logic b8, input logic qn,
                          input logic [63:0] pat);
    logic [31:0] rd;
    logic [31:0] rh;
    logic        err;
    logic [2:0]  qv;
    logic [6:0]  m;
    logic [63:0] msk;
    logic [3:0]  ua;
    qv  = 3'($urandom);
    msk = '0;
    apb(1'b1, ump_pkg::IDX_CTRL, {29'h0, qn, b8, 1'b0}, rd, err);
    repeat (100) @(posedge clk);
    apb(1'b1, ump_pkg::IDX_PMAP, {28'h0, sel}, rd, err);
    apb(1'b1, ump_pkg::IDX_QCFG, {29'h0, qv}, rd, err);
    // Unused table slots hold noise so that a wrongly polled port shows up
    tab = {$urandom, $urandom};
    for (int p = 0; p < 64; p++) begin
      m = exp_pos(sel, b8, p);
      if (m[6]) begin
        tab[m[5:4]*16+m[3:0]] = pat[p];
        msk[p] = 1'b1;
      end
    end
    repeat (3) @(posedge clk);
    chk(queues_per_phy, exp_q(sel, b8, qn, qv));
    chk(sel_unsupported, !msk[0]);
    apb(1'b0, ump_pkg::IDX_STAT, '0, rd, err);
    chk({rd[6:4], rd[0]}, {exp_q(sel, b8, qn, qv), !msk[0]});
    apb(1'b1, ump_pkg::IDX_CTRL, {29'h0, qn, b8, 1'b1}, rd, err);
    if (msk[0]) begin
      repeat (1500) @(posedge clk);
      chk(cell_avail & msk, pat & msk);
      apb(1'b0, ump_pkg::IDX_AVAIL_L, '0, rd, err);
      apb(1'b0, ump_pkg::IDX_AVAIL_H, '0, rh, err);
      chk({rh, rd} & msk, pat & msk);
    end else begin
      repeat (20) @(posedge clk);
      ua = u_addr;
      repeat (200) @(posedge clk);
      chk(u_addr, ua);
    end
  endtask : run_case

  task automatic wrap_up;
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    logic [31:0] rd;
    logic        err;
    error_cnt   = 0;
    checks_done = 0;
    arst_n      = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = '0;
    pwdata      = '0;
    tab         = '0;
    void'($urandom(71));
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(queues_per_phy, 3'h4);
    apb(1'b0, ump_pkg::IDX_CTRL, '0, rd, err);
    chk({err, rd}, {1'b0, 29'h0, ump_pkg::CTRL_RST});
    apb(1'b0, ump_pkg::IDX_PMAP, '0, rd, err);
    chk({err, rd}, {1'b0, 16'h0, ump_pkg::PMAP_RST});
    apb(1'b0, ump_pkg::IDX_QCFG, '0, rd, err);
    chk({err, rd}, {1'b0, 29'h0, ump_pkg::QCFG_RST});
    apb(1'b1, 10'h171, 32'hFFFF_FFFF, rd, err);
    chk(err, 1'b1);
    apb(1'b0, 10'h171, '0, rd, err);
    chk(err, 1'b1);
    run_case(4'h0, 1'b0, 1'b1, 64'h0000_0000_0000_0040);
    run_case(4'hE, 1'b1, 1'b1, 64'h8100_0000_0000_0000);
    run_case(4'hE, 1'b1, 1'b1, 64'h0081_0000_0000_0000);
    foreach (CASES[i]) begin
      run_case(CASES[i][5:2], CASES[i][1], CASES[i][0], {$urandom, $urandom});
    end
    wrap_up();
  end
endmodule : ump_port_map_tb
